// ### inc/csig_pkg.sv
package csig_pkg;

    // ***********************************************
    // Geometry
    // ***********************************************
    localparam int NUM_SOCK = 2;
    localparam int ADDR_W = 16;
    localparam int IDX_W = 14;
    localparam int SEL_W = 4;
    localparam int IRQ_W = 16;
    localparam int SYNC_W = 8;

    // ***********************************************
    // Register indices (byte address = 4 * index)
    // ***********************************************
    localparam logic [IDX_W-1:0] CTRL_IDX = 14'h0803;
    localparam logic [IDX_W-1:0] SOCK_SPAN_IDX = 14'h1000;
    localparam logic [IDX_W-1:0] LEGACY_A_IDX = 14'h0003;
    localparam logic [IDX_W-1:0] LEGACY_B_IDX = 14'h0043;
    localparam logic [IDX_W-1:0] DIAG_IDX = 14'h00F0;
    localparam logic [IDX_W-1:0] CSC_CFG_IDX = 14'h00F1;
    localparam logic [IDX_W-1:0] STAT_IDX = 14'h00F8;

    // ***********************************************
    // Fields and reset values
    // ***********************************************
    localparam int RING_BIT = 7;
    localparam int RUN_BIT = 6;
    localparam int KIND_BIT = 5;
    localparam int CSC_HOST_BIT = 4;
    localparam int SEL_LSB = 0;
    localparam int DIAG_ROUTE_BIT = 5;
    localparam int PME_EN_BIT = 0;
    localparam int CSC_SEL_LSB = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DIAG_RST = 8'h20;
    localparam logic [7:0] CSC_CFG_RST = 8'h00;

    // ***********************************************
    // Interrupt select codes
    // ***********************************************
    localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
    localparam logic [SEL_W-1:0] SEL_IRQ1 = 4'h1;
    localparam logic [SEL_W-1:0] SEL_SMI = 4'h2;
    localparam logic [SEL_W-1:0] SEL_IRQ4 = 4'h4;
    localparam logic [SEL_W-1:0] SEL_IRQ6 = 4'h6;
    localparam logic [SEL_W-1:0] SEL_IRQ8 = 4'h8;
    localparam logic [SEL_W-1:0] SEL_IRQ9 = 4'h9;

    // ***********************************************
    // Bus answers
    // ***********************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic {RD_IDLE, RD_RESP} csig_rd_e;

    typedef struct packed {
        logic ring_indicate_enable;
        logic cardRun;
        logic cardIo;
        logic cscHost;
        logic [SEL_W-1:0] irqSel;
    } csig_ctrl_s;

    typedef struct packed {
        logic pci;
        logic system_mgmt_interrupt;
        logic [IRQ_W-1:0] irq;
    } csig_route_s;

endpackage : csig_pkg

// ### design/csig_sock_reg.sv
`timescale 1ns/1ps

module csig_sock_reg
    import csig_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic globalClear,
    input wire logic busClear,
    input wire logic pmeEnable,
    input wire logic diagRoute,
    input wire logic [SEL_W-1:0] cscSel,
    input wire logic cscEvent,
    input wire logic funcIrq,
    output csig_ctrl_s ctrl,
    output csig_route_s route
);

    // ***********************************************
    // Destination decode
    // ***********************************************
    function automatic csig_route_s destOf(input logic [SEL_W-1:0] sel);
        csig_route_s d;
        d = '0;
        case (sel)
            SEL_IRQ1: d.irq[1] = 1'b1;
            SEL_SMI: d.system_mgmt_interrupt = 1'b1;
            SEL_IRQ4: d.irq[4] = 1'b1;
            SEL_IRQ6: d.irq[6] = 1'b1;
            SEL_IRQ8: d.irq[8] = 1'b1;
            SEL_IRQ9: d.irq[9] = 1'b1;
            default: d = '0;
        endcase
        return d;
    endfunction : destOf

    // ***********************************************
    // Control register
    // ***********************************************
    csig_ctrl_s ctrl_reg;
    csig_ctrl_s busCleared;

    // Card run and card kind survive a bus reset while wake events are on
    always_comb begin
        busCleared = CTRL_RST;
        if (pmeEnable) begin
            busCleared.cardRun = ctrl_reg.cardRun;
            busCleared.cardIo = ctrl_reg.cardIo;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || globalClear) begin
            ctrl_reg <= CTRL_RST;
        end else if (busClear) begin
            ctrl_reg <= busCleared;
        end else if (wrEn) begin
            ctrl_reg <= wrData;
        end
    end

    assign ctrl = ctrl_reg;

    // ***********************************************
    // Interrupt routing
    // ***********************************************
    wire logic selNone = (ctrl_reg.irqSel == SEL_NONE);
    wire logic cscToHost = (!diagRoute && ctrl_reg.cscHost) || selNone;
    wire logic funcActive = ctrl_reg.cardIo && funcIrq;
    wire csig_route_s cscDest = destOf(cscSel);
    wire csig_route_s funcDest = destOf(ctrl_reg.irqSel);

    always_comb begin
        route = '0;
        if (cscEvent) begin
            if (cscToHost) begin
                route.pci = 1'b1;
            end else begin
                route = cscDest;
            end
        end
        if (funcActive) begin
            route.system_mgmt_interrupt = route.system_mgmt_interrupt | funcDest.system_mgmt_interrupt;
            route.irq = route.irq | funcDest.irq;
        end
    end

endmodule : csig_sock_reg

// ### design/csig_sock_ctrl.sv
`timescale 1ns/1ps

module csig_sock_ctrl
    import csig_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic globalResetPin_n,
    input wire logic busResetPin_n,
    input wire logic [NUM_SOCK-1:0] batteryRingPin,
    input wire logic [NUM_SOCK-1:0] cardIrqPin_n,
    input wire logic [NUM_SOCK-1:0] card32Bit,
    input wire logic [NUM_SOCK-1:0] cscEvent,
    output logic [NUM_SOCK-1:0] cardReset,
    output logic [NUM_SOCK-1:0] ringIndicate,
    output logic [NUM_SOCK-1:0] batteryDetect,
    output logic [NUM_SOCK-1:0] cardIsIo,
    output logic [NUM_SOCK-1:0] pciIntr,
    output logic [IRQ_W-1:0] legacyIrq,
    output logic sysMgmtIrq
);

    // ***********************************************
    // Pin synchronisers
    // ***********************************************
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;

    wire logic [SYNC_W-1:0] pinsRaw = {
        globalResetPin_n, busResetPin_n, batteryRingPin, cardIrqPin_n, card32Bit
    };

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end else begin
            sync1_reg <= pinsRaw;
            sync2_reg <= sync1_reg;
        end
    end

    wire logic globalClear = !sync2_reg[7];
    wire logic busClear = !sync2_reg[6];
    wire logic [NUM_SOCK-1:0] ringPinSync = sync2_reg[5:4];
    wire logic [NUM_SOCK-1:0] funcIrqSync = ~sync2_reg[3:2];
    wire logic [NUM_SOCK-1:0] card32Sync = sync2_reg[1:0];

    // ***********************************************
    // Write channel
    // ***********************************************
    logic awHeld_reg;
    logic wHeld_reg;
    logic [IDX_W-1:0] awIdx_reg;
    logic [7:0] wByte_reg;
    logic wLane_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    wire logic awFire = awvalid && awready_reg;
    wire logic wFire = wvalid && wready_reg;
    wire logic doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
    wire logic bDone = bvalid_reg && bready;
    wire logic awHeld_next = (awHeld_reg || awFire) && !doWrite;
    wire logic wHeld_next = (wHeld_reg || wFire) && !doWrite;
    wire logic bvalid_next = doWrite || (bvalid_reg && !bready);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
        end else begin
            awHeld_reg <= awHeld_next;
            wHeld_reg <= wHeld_next;
            awready_reg <= !awHeld_next && !bvalid_next && !doWrite;
            wready_reg <= !wHeld_next && !bvalid_next && !doWrite;
            bvalid_reg <= bvalid_next;
        end
    end

    // ***********************************************
    // Write decode
    // ***********************************************
    logic [NUM_SOCK-1:0] wrCtrlHit;
    logic [NUM_SOCK-1:0] wrCfgHit;

    wire logic wrDiagHit = (awIdx_reg == DIAG_IDX);
    wire logic wrStatHit = (awIdx_reg == STAT_IDX);
    wire logic wrMapped = (|wrCtrlHit) || (|wrCfgHit) || wrDiagHit || wrStatHit;
    wire logic wrCommit = doWrite && wLane_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awIdx_reg <= '0;
            wByte_reg <= '0;
            wLane_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (awFire) begin
                awIdx_reg <= awaddr[ADDR_W-1:2];
            end
            if (wFire) begin
                wByte_reg <= wdata[7:0];
                wLane_reg <= wstrb[0];
            end
            if (doWrite) begin
                bresp_reg <= wrMapped ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    // ***********************************************
    // Global configuration registers
    // ***********************************************
    logic [7:0] diag_reg;
    logic [7:0] cscCfg_reg [NUM_SOCK];

    always_ff @(posedge clk) begin
        if (!rst_n || globalClear) begin
            diag_reg <= DIAG_RST;
        end else if (wrCommit && wrDiagHit) begin
            diag_reg <= wByte_reg;
        end
    end

    wire logic diagRoute = diag_reg[DIAG_ROUTE_BIT];
    wire logic pmeEnable = diag_reg[PME_EN_BIT];

    // ***********************************************
    // Per-socket control
    // ***********************************************
    csig_ctrl_s ctrlVal [NUM_SOCK];
    csig_route_s routeVal [NUM_SOCK];
    logic [7:0] rdSock [NUM_SOCK];
    logic [7:0] rdCfg [NUM_SOCK];
    logic [NUM_SOCK-1:0] rdCtrlHit;
    logic [NUM_SOCK-1:0] rdCfgHit;

    wire logic [IDX_W-1:0] arIdx = araddr[ADDR_W-1:2];

    genvar s;
    generate
        for (s = 0; s < NUM_SOCK; s++) begin : g_sock
            localparam logic [IDX_W-1:0] SOCK_IDX = IDX_W'(CTRL_IDX + s * SOCK_SPAN_IDX);
            localparam logic [IDX_W-1:0] CFG_IDX = IDX_W'(CSC_CFG_IDX + s);
            localparam logic [IDX_W-1:0] ALIAS_IDX = (s == 0) ? LEGACY_A_IDX : LEGACY_B_IDX;

            assign wrCtrlHit[s] = (awIdx_reg == SOCK_IDX) || (awIdx_reg == ALIAS_IDX);
            assign wrCfgHit[s] = (awIdx_reg == CFG_IDX);
            assign rdCtrlHit[s] = (arIdx == SOCK_IDX) || (arIdx == ALIAS_IDX);
            assign rdCfgHit[s] = (arIdx == CFG_IDX);
            assign rdSock[s] = ctrlVal[s];
            assign rdCfg[s] = cscCfg_reg[s];

            always_ff @(posedge clk) begin
                if (!rst_n || globalClear) begin
                    cscCfg_reg[s] <= CSC_CFG_RST;
                end else if (wrCommit && wrCfgHit[s]) begin
                    cscCfg_reg[s] <= wByte_reg;
                end
            end

            csig_sock_reg u_sock (
                .clk(clk),
                .rst_n(rst_n),
                .wrEn(wrCommit && wrCtrlHit[s]),
                .wrData(wByte_reg),
                .globalClear(globalClear),
                .busClear(busClear),
                .pmeEnable(pmeEnable),
                .diagRoute(diagRoute),
                .cscSel(cscCfg_reg[s][CSC_SEL_LSB +: SEL_W]),
                .cscEvent(cscEvent[s]),
                .funcIrq(funcIrqSync[s]),
                .ctrl(ctrlVal[s]),
                .route(routeVal[s])
            );

            // Card-side pins
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cardReset[s] <= 1'b0;
                    ringIndicate[s] <= 1'b0;
                    batteryDetect[s] <= 1'b0;
                    cardIsIo[s] <= 1'b0;
                    pciIntr[s] <= 1'b0;
                end else begin
                    cardReset[s] <= !ctrlVal[s].cardRun && !card32Sync[s];
                    ringIndicate[s] <= ctrlVal[s].ring_indicate_enable && !ringPinSync[s];
                    batteryDetect[s] <= !ctrlVal[s].ring_indicate_enable && ringPinSync[s];
                    cardIsIo[s] <= ctrlVal[s].cardIo;
                    pciIntr[s] <= routeVal[s].pci;
                end
            end
        end
    endgenerate

    // ***********************************************
    // Shared interrupt lines
    // ***********************************************
    logic [IRQ_W-1:0] irqAny;
    logic smiAny;

    always_comb begin
        irqAny = '0;
        smiAny = 1'b0;
        for (int i = 0; i < NUM_SOCK; i++) begin
            irqAny = irqAny | routeVal[i].irq;
            smiAny = smiAny | routeVal[i].system_mgmt_interrupt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            legacyIrq <= '0;
            sysMgmtIrq <= 1'b0;
        end else begin
            legacyIrq <= irqAny;
            sysMgmtIrq <= smiAny;
        end
    end

    // ***********************************************
    // Read channel
    // ***********************************************
    csig_rd_e rdState_reg;
    logic arready_reg;
    logic [7:0] rByte_reg;
    logic [1:0] rresp_reg;
    logic [7:0] rdMux;
    logic rdMapped;

    wire logic arFire = arvalid && arready_reg;
    wire logic [7:0] statByte = {2'b00, card32Sync, ringPinSync, funcIrqSync};

    always_comb begin
        rdMux = '0;
        rdMapped = 1'b0;
        if (arIdx == DIAG_IDX) begin
            rdMux = diag_reg;
            rdMapped = 1'b1;
        end
        if (arIdx == STAT_IDX) begin
            rdMux = statByte;
            rdMapped = 1'b1;
        end
        for (int i = 0; i < NUM_SOCK; i++) begin
            if (rdCtrlHit[i]) begin
                rdMux = rdSock[i];
                rdMapped = 1'b1;
            end
            if (rdCfgHit[i]) begin
                rdMux = rdCfg[i];
                rdMapped = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdState_reg <= RD_IDLE;
            arready_reg <= 1'b0;
            rByte_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            case (rdState_reg)
                RD_IDLE: begin
                    arready_reg <= !arFire;
                    if (arFire) begin
                        rdState_reg <= RD_RESP;
                        rByte_reg <= rdMux;
                        rresp_reg <= rdMapped ? RESP_OKAY : RESP_DECERR;
                    end
                end
                RD_RESP: begin
                    if (rready) begin
                        rdState_reg <= RD_IDLE;
                        arready_reg <= 1'b1;
                    end
                end
                default: begin
                    rdState_reg <= RD_IDLE;
                    arready_reg <= 1'b0;
                end
            endcase
        end
    end

    // ***********************************************
    // Bus outputs
    // ***********************************************
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = (rdState_reg == RD_RESP);
    assign rdata = {24'h000000, rByte_reg};
    assign rresp = rresp_reg;

endmodule : csig_sock_ctrl

// ### dv/csig_sock_ctrl_asserts.sv
`timescale 1ns/1ps

module csig_sock_ctrl_asserts
    import csig_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic globalResetPin_n,
    input wire logic busResetPin_n,
    input wire logic [NUM_SOCK-1:0] card32Bit,
    input wire logic [NUM_SOCK-1:0] cardReset,
    input wire logic [NUM_SOCK-1:0] ringIndicate,
    input wire logic [NUM_SOCK-1:0] batteryDetect,
    input wire logic [NUM_SOCK-1:0] cardIsIo,
    input wire logic [IRQ_W-1:0] legacyIrq,
    input wire logic sysMgmtIrq
);
    // ********
    // Pin history, newest sample in bit 0
    // ********
    logic [4:0] glbHist_reg, busHist_reg, c32Hist_reg;

    always_ff @(posedge clk) begin
        glbHist_reg <= {glbHist_reg[3:0], globalResetPin_n};
        busHist_reg <= {busHist_reg[3:0], busResetPin_n};
        c32Hist_reg <= {c32Hist_reg[3:0], card32Bit[0]};
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write response not two cycles after take");
    a_aw_stands: assert property (awvalid && awready |=> !awready [*2])
        else $error("write address ready back too early");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready && rdata[31:8] == 24'h000000)
        else $error("read answer wrong");
    a_resp_code: assert property (bvalid |-> bresp == RESP_OKAY || bresp == RESP_DECERR)
        else $error("illegal write response code");
    a_ring_excl: assert property (!(|(ringIndicate & batteryDetect)))
        else $error("ring and battery detect both active");
    a_card32_free: assert property (c32Hist_reg == 5'h1F && card32Bit[0] |-> !cardReset[0])
        else $error("32-bit card held in reset");
    a_global_clear: assert property (glbHist_reg == 5'h00 && !globalResetPin_n |-> cardIsIo == '0 && ringIndicate == '0)
        else $error("global reset left control bits set");
    a_bus_clear: assert property (busHist_reg == 5'h00 && !busResetPin_n |-> ringIndicate == '0 && legacyIrq == '0 && !sysMgmtIrq)
        else $error("bus reset left control bits set");

    c_decerr: cover property (bvalid && bresp == RESP_DECERR);
    c_irq: cover property (|legacyIrq);
    c_smi: cover property (sysMgmtIrq);

endmodule : csig_sock_ctrl_asserts

bind csig_sock_ctrl csig_sock_ctrl_asserts i_csig_sock_ctrl_asserts (
    .clk, .rst_n, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .arvalid,
    .arready, .rdata, .rvalid, .globalResetPin_n, .busResetPin_n, .card32Bit,
    .cardReset, .ringIndicate, .batteryDetect, .cardIsIo, .legacyIrq, .sysMgmtIrq
);

// ### dv/csig_card_model.sv
`timescale 1ns/1ps

module csig_card_model
    import csig_pkg::*;
(
    input wire logic clk,
    input wire logic [NUM_SOCK-1:0] cardReset,
    input wire logic [NUM_SOCK-1:0] wantIrq,
    input wire logic [NUM_SOCK-1:0] ringLevel,
    input wire logic [NUM_SOCK-1:0] is32,
    output logic [NUM_SOCK-1:0] batteryRingPin = '0,
    output logic [NUM_SOCK-1:0] cardIrqPin_n = '1,
    output logic [NUM_SOCK-1:0] card32Bit = '0
);
    // A card held in reset cannot raise its interrupt line
    always_ff @(posedge clk) begin
        cardIrqPin_n <= ~(wantIrq & ~cardReset);
        batteryRingPin <= ringLevel;
        card32Bit <= is32;
    end
endmodule : csig_card_model

// ### dv/tb_card_socket_irq_general_control.sv
`timescale 1ns/1ps

module tb_card_socket_irq_general_control
    import csig_pkg::*;
;
    localparam logic [15:0] CA = {CTRL_IDX, 2'b00};
    localparam logic [15:0] CB = {CTRL_IDX + SOCK_SPAN_IDX, 2'b00};
    localparam logic [15:0] LA = {LEGACY_A_IDX, 2'b00};
    localparam logic [15:0] LB = {LEGACY_B_IDX, 2'b00};
    localparam logic [15:0] DIAG = {DIAG_IDX, 2'b00};
    localparam logic [15:0] CFGA = {CSC_CFG_IDX, 2'b00};
    localparam logic [15:0] BAD = 16'h0400;

    logic clk = 1'b0, rst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic globalResetPin_n = 1'b1, busResetPin_n = 1'b1;
    logic [NUM_SOCK-1:0] wantIrq = '0, ringLevel = '0, is32 = '0, cscEvent = '0;
    logic awready, wready, bvalid, arready, rvalid, sysMgmtIrq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [NUM_SOCK-1:0] batteryRingPin, cardIrqPin_n, card32Bit, cardReset;
    logic [NUM_SOCK-1:0] ringIndicate, batteryDetect, cardIsIo, pciIntr;
    logic [IRQ_W-1:0] legacyIrq;
    int fails = 0, checks = 0;

    always #4 clk = ~clk;

    csig_sock_ctrl i_csig_sock_ctrl (
        .clk, .rst_n, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .globalResetPin_n, .busResetPin_n,
        .batteryRingPin, .cardIrqPin_n, .card32Bit, .cscEvent, .cardReset, .ringIndicate,
        .batteryDetect, .cardIsIo, .pciIntr, .legacyIrq, .sysMgmtIrq
    );

    csig_card_model i_csig_card_model (
        .clk, .cardReset, .wantIrq, .ringLevel, .is32, .batteryRingPin, .cardIrqPin_n,
        .card32Bit
    );

    // ********
    // Shared tasks
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic clks(input int n);
        repeat (n) @(posedge clk);
    endtask : clks

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1,
                      input logic [1:0] er = RESP_OKAY);
        bit aw, w;
        int n;
        aw = 0;
        w = 0;
        n = 0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w) && n < 64) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid && n < 64) begin
            @(posedge clk);
            n++;
        end
        check(bresp, er);
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] exp,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!arready && n < 64);
        arvalid <= 1'b0;
        while (!rvalid && n < 64) begin
            @(posedge clk);
            n++;
        end
        check(rresp, er);
        if (er === RESP_OKAY) check(rdata, exp);
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic pin_pulse(input bit glb);
        if (glb) globalResetPin_n <= 1'b0;
        else busResetPin_n <= 1'b0;
        clks(8);
        globalResetPin_n <= 1'b1;
        busResetPin_n <= 1'b1;
        clks(4);
    endtask : pin_pulse

    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        rd(CA, 32'h0);
        rd(LB, 32'h0);
        wr(CA, 8'hA5);
        rd(LA, 32'hA5);
        wr(CB, 8'h5A);
        rd(LB, 32'h5A);
        wr(CA, 8'h00, 4'h0);
        rd(CA, 32'hA5);
        wr(BAD, 8'hFF, 4'h1, RESP_DECERR);
        rd(BAD, 32'h0, RESP_DECERR);
        wr(CA, 8'h00);
        wr(CB, 8'h00);
    endtask : t_regs

    task automatic t_bits();
        ringLevel <= 2'b01;
        wr(CA, 8'h80);
        clks(4);
        check(ringIndicate, 2'b00);
        ringLevel <= 2'b00;
        clks(5);
        check(ringIndicate, 2'b01);
        wr(CA, 8'h00);
        ringLevel <= 2'b11;
        clks(5);
        check({ringIndicate, batteryDetect}, 4'h3);
        check(cardReset, 2'b11);
        wr(CA, 8'h40);
        clks(2);
        check(cardReset, 2'b10);
        wr(CA, 8'h20);
        clks(2);
        check({cardReset, cardIsIo}, 4'hD);
        is32 <= 2'b11;
        clks(6);
        check(cardReset, 2'b00);
        is32 <= 2'b00;
        ringLevel <= 2'b00;
        wr(CA, 8'h00);
    endtask : t_bits

    task automatic t_csc();
        wr(CFGA, {SEL_IRQ4, 4'h0});
        wr(CA, {4'h1, SEL_IRQ1});
        cscEvent <= 2'b01;
        clks(3);
        check({pciIntr, legacyIrq}, 18'h00010);
        wr(DIAG, 8'h00);
        clks(2);
        check({pciIntr, legacyIrq}, 18'h10000);
        wr(CA, {4'h0, SEL_IRQ1});
        clks(2);
        check({pciIntr, legacyIrq}, 18'h00010);
        wr(CA, 8'h00);
        clks(2);
        check({pciIntr, legacyIrq}, 18'h10000);
        cscEvent <= 2'b00;
        wr(CFGA, 8'h00);
        wr(DIAG, DIAG_RST);
    endtask : t_csc

    task automatic t_codes();
        logic [IRQ_W-1:0] expIrq;
        wantIrq <= 2'b01;
        for (int c = 0; c < 16; c++) begin
            wr(CA, 8'h60 | 8'(c));
            clks(6);
            expIrq = 16'h0000;
            if (c inside {1, 4, 6, 8, 9}) expIrq = 16'h0001 << c;
            check(legacyIrq, expIrq);
            check(sysMgmtIrq, c == 2);
        end
        wr(CA, {4'h4, SEL_IRQ9});
        clks(2);
        check(legacyIrq, 16'h0000);
        wantIrq <= 2'b00;
        wr(CA, 8'h00);
    endtask : t_codes

    task automatic t_pins();
        wr(CA, 8'hFF);
        pin_pulse(1'b0);
        rd(CA, 32'h00);
        wr(DIAG, 8'h01);
        wr(CA, 8'hFF);
        pin_pulse(1'b0);
        rd(CA, 32'h60);
        pin_pulse(1'b1);
        rd(CA, 32'h00);
    endtask : t_pins

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        clks(5);
        t_regs();
        t_bits();
        t_csc();
        t_codes();
        t_pins();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : tb_card_socket_irq_general_control
